// ### design/rxfc_pkg.sv
package rxfc_pkg;

    // Register word offsets in bytes.
    localparam logic [7:0] OFF_UNI_SET   = 8'h00;
    localparam logic [7:0] OFF_UNI_CLR   = 8'h04;
    localparam logic [7:0] OFF_MAXLEN    = 8'h08;
    localparam logic [7:0] OFF_BUF_OFS   = 8'h0c;
    localparam logic [7:0] OFF_LOW_THR   = 8'h10;
    localparam logic [7:0] OFF_FLOW_CTL  = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
    localparam logic [7:0] OFF_FLOW_THR0 = 8'h20;
    localparam logic [7:0] OFF_FREE_CNT0 = 8'h40;
    localparam logic [7:0] OFF_LIMIT     = 8'h60;

    localparam logic [15:0] MAXLEN_RST  = 16'h05ee;
    localparam logic [15:0] BUF_OFS_RST = 16'h0000;
    localparam logic [7:0]  THR_RST     = 8'h00;
    localparam logic [7:0]  UNI_RST     = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // Interrupt status bit positions.
    localparam int IRQ_LONG   = 0;
    localparam int IRQ_OVER   = 1;
    localparam int IRQ_JABBER = 2;
    localparam int IRQ_LOWF   = 3;
    localparam int IRQ_FLOW   = 4;
    localparam int IRQ_W      = 5;

    // One received frame as reported at end of frame.
    typedef struct packed {
        logic [2:0]  chan;
        logic [15:0] byte_count;
        logic        crc_err;
        logic        code_err;
        logic        align_err;
        logic        low_prio;
    } rxfc_frame_t;

    // Classification result for that frame.
    typedef struct packed {
        logic        long_frame;
        logic        oversized;
        logic        jabber;
        logic        low_filtered;
        logic        flow_ctl;
        logic [15:0] sop_buf_offset;
    } rxfc_class_t;

    typedef enum logic [1:0] {
        RXFC_IDLE = 2'b00,
        RXFC_RESP = 2'b01
    } rxfc_bus_state_t;

endpackage

// ### design/rxfc_classify.sv
`timescale 1ns/10ps
module rxfc_classify #(
    parameter int CH_N = 8
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // Frame in.
    input  wire logic                 frame_valid,
    input  wire rxfc_pkg::rxfc_frame_t frame,
    // Settings.
    input  wire logic [15:0]          max_len,
    input  wire logic [15:0]          buf_ofs,
    input  wire logic [7:0]           low_thr,
    input  wire logic [CH_N*8-1:0]    flow_thr,
    input  wire logic [CH_N*16-1:0]   free_cnt,
    input  wire logic                 flow_en,
    // Result out.
    output logic                      class_valid,
    output rxfc_pkg::rxfc_class_t     class_out
);

    logic [15:0] free_ch;
    logic [7:0]  flow_ch;
    logic        is_long;
    logic        any_err;

    always_comb begin
        free_ch = free_cnt[frame.chan*16 +: 16];
        flow_ch = flow_thr[frame.chan*8 +: 8];
        is_long = frame.byte_count > max_len; // [RULE4]
        any_err = frame.crc_err | frame.code_err | frame.align_err;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            class_valid <= 1'b0;
        end else begin
            class_valid <= frame_valid;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            class_out <= '0;
        end else if (frame_valid) begin
            class_out.long_frame     <= is_long;
            class_out.oversized      <= is_long & ~any_err; // [RULE5]
            class_out.jabber         <= is_long & any_err; // [RULE6]
            // Zero threshold disables filtering altogether.
            class_out.low_filtered   <= frame.low_prio && (low_thr != 8'h00)
                                        && (free_ch <= {8'h00, low_thr}); // [RULE14] [RULE17]
            class_out.flow_ctl       <= flow_en && (free_ch <= {8'h00, flow_ch}); // [RULE15]
            // One offset for every channel; zero means data starts at byte 0.
            class_out.sop_buf_offset <= buf_ofs; // [RULE7] [RULE8] [RULE9] [RULE10]
        end
    end

endmodule

// ### design/rxfc_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] A one written to bit n of the clear register clears channel n unicast enable.
// [RULE2] All eight unicast enables reset to zero.
// [RULE3] The frame length limit is a 16-bit read/write field resetting to 1518.
// [RULE4] A frame longer than the limit is a long frame.
// [RULE5] A long frame with no error is oversized.
// [RULE6] A long frame with a CRC, code or alignment error is a jabber frame.
// [RULE7] The buffer offset is copied into each start-of-packet descriptor offset field.
// [RULE8] Frame data begins after the offset number of bytes in the first buffer.
// [RULE9] An offset of zero places data at the first byte of the buffer.
// [RULE10] One offset serves all channels.
// [RULE11] The low-priority threshold is an 8-bit read/write field resetting to zero.
// [RULE12] Software keeps the low-priority threshold at zero when no filtering is wanted.
// [RULE13] Each of the eight channels has an 8-bit flow threshold resetting to zero.
// [RULE14] The low-priority threshold is compared with each channel free-buffer count.
// [RULE15] With flow control on, each flow threshold is compared with its free count.
// [RULE16] A one written to bit n of the set register sets channel n unicast enable.
// [RULE17] A low-priority frame is filtered when free count is at or below a nonzero threshold.
//////////////////////////////////////////////////////////////////////////////////////////
module rxfc_top #(
    parameter int CH_N = 8
) (
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // Avalon-MM slave.
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // Received frame report.
    input  wire logic                  frame_valid,
    input  wire rxfc_pkg::rxfc_frame_t frame,
    // Classification and enables.
    output logic                       class_valid,
    output rxfc_pkg::rxfc_class_t      class_out,
    output logic [CH_N-1:0]            channel_unicast_enable_bit,
    output logic [CH_N-1:0]            channel_flow_assert,
    // Interrupt.
    output logic                       irq
);

    logic [CH_N-1:0]           uni_en_r;
    logic [15:0]               maxlen_r;
    logic [15:0]               bufofs_r;
    logic [7:0]                lowthr_r;
    logic                      flow_en_r;
    logic [CH_N*8-1:0]         flowthr_r;
    logic [CH_N*16-1:0]        freecnt_r;
    logic [rxfc_pkg::IRQ_W-1:0] stat_r;
    logic [rxfc_pkg::IRQ_W-1:0] mask_r;
    logic [31:0]               rdata_r;
    rxfc_pkg::rxfc_bus_state_t bus_r;
    logic                      wr_fire;
    logic                      rd_fire;
    logic [31:0]               rd_nxt;
    logic [rxfc_pkg::IRQ_W-1:0] ev;
    logic [31:0]               be_mask;

    //////////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: every access is answered on the second cycle, so read data
    // come from a flop and the decode has a full cycle.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bus_r <= rxfc_pkg::RXFC_IDLE;
        end else begin
            unique case (bus_r)
                rxfc_pkg::RXFC_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_r <= rxfc_pkg::RXFC_RESP;
                    end
                end
                rxfc_pkg::RXFC_RESP: begin
                    bus_r <= rxfc_pkg::RXFC_IDLE;
                end
                default: begin
                    bus_r <= rxfc_pkg::RXFC_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && (bus_r != rxfc_pkg::RXFC_RESP);
        wr_fire         = avs_write && (bus_r == rxfc_pkg::RXFC_RESP);
        rd_fire         = avs_read && (bus_r == rxfc_pkg::RXFC_IDLE);
        be_mask         = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Unicast enables.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            uni_en_r <= rxfc_pkg::UNI_RST; // [RULE2]
        end else if (wr_fire && avs_byteenable[0]) begin
            if (avs_address == rxfc_pkg::OFF_UNI_SET) begin
                uni_en_r <= uni_en_r | avs_writedata[CH_N-1:0]; // [RULE16]
            end else if (avs_address == rxfc_pkg::OFF_UNI_CLR) begin
                uni_en_r <= uni_en_r & ~avs_writedata[CH_N-1:0]; // [RULE1]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Plain read/write settings.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            maxlen_r  <= rxfc_pkg::MAXLEN_RST; // [RULE3]
            bufofs_r  <= rxfc_pkg::BUF_OFS_RST;
            lowthr_r  <= rxfc_pkg::THR_RST; // [RULE11]
            flow_en_r <= 1'b0;
            mask_r    <= '0;
        end else if (wr_fire) begin
            unique case (avs_address)
                rxfc_pkg::OFF_MAXLEN: begin
                    maxlen_r <= (maxlen_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
                end
                rxfc_pkg::OFF_BUF_OFS: begin
                    bufofs_r <= (bufofs_r & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
                end
                rxfc_pkg::OFF_LOW_THR: begin
                    if (avs_byteenable[0]) begin
                        lowthr_r <= avs_writedata[7:0];
                    end
                end
                rxfc_pkg::OFF_FLOW_CTL: begin
                    if (avs_byteenable[0]) begin
                        flow_en_r <= avs_writedata[0];
                    end
                end
                rxfc_pkg::OFF_IRQ_MASK: begin
                    if (avs_byteenable[0]) begin
                        mask_r <= avs_writedata[rxfc_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Per-channel flow thresholds and free-buffer counts.
    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : g_ch
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    flowthr_r[g*8 +: 8] <= rxfc_pkg::THR_RST; // [RULE13]
                end else if (wr_fire && avs_byteenable[0]
                             && avs_address == rxfc_pkg::OFF_FLOW_THR0 + 8'(g*4)) begin
                    flowthr_r[g*8 +: 8] <= avs_writedata[7:0]; // [RULE13]
                end
            end
            // Writes add freed buffers; a frame taken on this channel uses one.
            // Both in one cycle net out, so no buffer is lost to a race.
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    freecnt_r[g*16 +: 16] <= '0;
                end else begin
                    freecnt_r[g*16 +: 16] <= freecnt_r[g*16 +: 16]
                        + ((wr_fire && avs_address == rxfc_pkg::OFF_FREE_CNT0 + 8'(g*4))
                           ? avs_writedata[15:0] : 16'h0000)
                        - ((frame_valid && frame.chan == 3'(g)) ? 16'h0001 : 16'h0000);
                end
            end
            always_comb begin
                channel_flow_assert[g] = flow_en_r
                    && (freecnt_r[g*16 +: 16] <= {8'h00, flowthr_r[g*8 +: 8]}); // [RULE15]
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over the clear-on-read.
    always_comb begin
        ev                     = '0;
        ev[rxfc_pkg::IRQ_LONG]   = class_valid & class_out.long_frame;
        ev[rxfc_pkg::IRQ_OVER]   = class_valid & class_out.oversized;
        ev[rxfc_pkg::IRQ_JABBER] = class_valid & class_out.jabber;
        ev[rxfc_pkg::IRQ_LOWF]   = class_valid & class_out.low_filtered;
        ev[rxfc_pkg::IRQ_FLOW]   = class_valid & class_out.flow_ctl;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            stat_r <= '0;
        end else if (rd_fire && avs_address == rxfc_pkg::OFF_IRQ_STAT) begin
            stat_r <= ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_comb begin
        irq = |(stat_r & mask_r);
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Read mux; the set and clear addresses both read the current enables.
    always_comb begin
        rd_nxt = rxfc_pkg::UNMAPPED_RD;
        if (avs_address == rxfc_pkg::OFF_UNI_SET || avs_address == rxfc_pkg::OFF_UNI_CLR) begin
            rd_nxt[CH_N-1:0] = uni_en_r;
        end else if (avs_address == rxfc_pkg::OFF_MAXLEN) begin
            rd_nxt[15:0] = maxlen_r;
        end else if (avs_address == rxfc_pkg::OFF_BUF_OFS) begin
            rd_nxt[15:0] = bufofs_r;
        end else if (avs_address == rxfc_pkg::OFF_LOW_THR) begin
            rd_nxt[7:0] = lowthr_r;
        end else if (avs_address == rxfc_pkg::OFF_FLOW_CTL) begin
            rd_nxt[0] = flow_en_r;
        end else if (avs_address == rxfc_pkg::OFF_IRQ_STAT) begin
            rd_nxt[rxfc_pkg::IRQ_W-1:0] = stat_r;
        end else if (avs_address == rxfc_pkg::OFF_IRQ_MASK) begin
            rd_nxt[rxfc_pkg::IRQ_W-1:0] = mask_r;
        end else if (avs_address >= rxfc_pkg::OFF_FLOW_THR0
                     && avs_address < rxfc_pkg::OFF_FREE_CNT0) begin
            rd_nxt[7:0] = flowthr_r[avs_address[4:2]*8 +: 8];
        end else if (avs_address >= rxfc_pkg::OFF_FREE_CNT0
                     && avs_address < rxfc_pkg::OFF_LIMIT) begin
            rd_nxt[15:0] = freecnt_r[avs_address[4:2]*16 +: 16];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else if (rd_fire) begin
            rdata_r <= rd_nxt;
        end
    end

    always_comb begin
        avs_readdata               = rdata_r;
        channel_unicast_enable_bit = uni_en_r;
    end

    //////////////////////////////////////////////////////////////////////////////////////
    rxfc_classify #(
        .CH_N (CH_N)
    ) u_classify (
        .clock       (clock),
        .nrst        (nrst),
        .frame_valid (frame_valid),
        .frame       (frame),
        .max_len     (maxlen_r),
        .buf_ofs     (bufofs_r),
        .low_thr     (lowthr_r),
        .flow_thr    (flowthr_r),
        .free_cnt    (freecnt_r),
        .flow_en     (flow_en_r),
        .class_valid (class_valid),
        .class_out   (class_out)
    );

endmodule

// ### verification/rxfc_top_chk.sv
`timescale 1ns/10ps
module rxfc_top_chk #(
    parameter int CH_N = 8
) (
    // Clock and reset.
    input wire logic                  clock,
    input wire logic                  nrst,
    // Register bus.
    input wire logic [7:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic [3:0]            avs_byteenable,
    input wire logic                  avs_waitrequest,
    // Frames and results.
    input wire logic                  frame_valid,
    input wire rxfc_pkg::rxfc_frame_t frame,
    input wire logic                  class_valid,
    input wire rxfc_pkg::rxfc_class_t class_out,
    input wire logic [CH_N-1:0]       channel_unicast_enable_bit,
    input wire logic                  irq
);
    logic err_r;
    wire  wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    always_ff @(posedge clock) begin
        err_r <= frame.crc_err | frame.code_err | frame.align_err;
    end

    chk_class_pulse: assert property (frame_valid |=> class_valid)
        else $error("class pulse missing");
    chk_class_hold: assert property (!frame_valid |=> !class_valid && $stable(class_out))
        else $error("class result moved without a frame");
    chk_over_rule: assert property (class_valid |->
        class_out.oversized == (class_out.long_frame && !err_r))
        else $error("oversized class wrong");
    chk_jabber_rule: assert property (class_valid |->
        class_out.jabber == (class_out.long_frame && err_r))
        else $error("jabber class wrong");
    chk_wait_one: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait cycle count wrong");
    chk_reset_zero: assert property ($rose(nrst) |->
        channel_unicast_enable_bit == '0 && !irq && !class_valid)
        else $error("outputs not clear after reset");
    chk_uni_clear: assert property (wr_ok && avs_address == rxfc_pkg::OFF_UNI_CLR |=>
        channel_unicast_enable_bit ==
        ($past(channel_unicast_enable_bit) & ~$past(avs_writedata[CH_N-1:0])))
        else $error("unicast clear wrong");
    chk_uni_set: assert property (wr_ok && avs_address == rxfc_pkg::OFF_UNI_SET |=>
        channel_unicast_enable_bit ==
        ($past(channel_unicast_enable_bit) | $past(avs_writedata[CH_N-1:0])))
        else $error("unicast set wrong");
endmodule

bind rxfc_top rxfc_top_chk #(.CH_N(CH_N)) u_rxfc_top_chk (
    .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid), .frame(frame),
    .class_valid(class_valid), .class_out(class_out),
    .channel_unicast_enable_bit(channel_unicast_enable_bit), .irq(irq));

// ### verification/rxfc_phy_model.sv
`timescale 1ns/10ps
module rxfc_phy_model (
    // Clock.
    input  wire logic                  clock,
    // Request from the bench.
    input  wire logic                  send,
    input  wire rxfc_pkg::rxfc_frame_t frame_in,
    // Report toward the block.
    output logic                       frame_valid,
    output rxfc_pkg::rxfc_frame_t      frame
);
    initial begin
        frame_valid = 1'b0;
        frame = '0;
    end
    // Between reports the fields flip each cycle, so a stale frame can never pass as valid.
    always @(posedge clock) begin
        frame_valid <= send;
        frame <= send ? frame_in : ~frame;
    end
endmodule

// ### verification/rxfc_top_tb.sv
`timescale 1ns/10ps
module rxfc_top_tb;
    logic                  clock, nrst, rd, wr, send, frame_valid, class_valid, waitreq, irq;
    logic [7:0]            addr, uni, flow;
    logic [31:0]           wdata, rdata, v;
    rxfc_pkg::rxfc_frame_t fin, frame;
    rxfc_pkg::rxfc_class_t cls;
    int                    fail_count, tests_run, cyc;
    // Byte count, error bits, then expected long, oversized and jabber.
    localparam logic [21:0] ROWS [6] = '{{16'd1518, 3'b000, 3'b000}, {16'd1519, 3'b000, 3'b110},
        {16'd1519, 3'b100, 3'b101}, {16'd1519, 3'b010, 3'b101}, {16'd1519, 3'b001, 3'b101},
        {16'd1000, 3'b100, 3'b000}};

    rxfc_phy_model u_rxfc_phy_model (.clock(clock), .send(send), .frame_in(fin),
        .frame_valid(frame_valid), .frame(frame));
    rxfc_top u_rxfc_top (.clock(clock), .nrst(nrst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .frame_valid(frame_valid), .frame(frame),
        .class_valid(class_valid), .class_out(cls), .channel_unicast_enable_bit(uni),
        .channel_flow_assert(flow), .irq(irq));

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The request stands until an edge that sees waitrequest low; data and release go there.
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clock); while (waitreq);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(what, e, v);
    endtask
    task automatic frm(logic [2:0] ch, logic [15:0] n, logic [2:0] err, logic lp);
        @(posedge clock);
        send <= 1'b1;
        fin <= {ch, n, err, lp};
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        check("class_valid", 1, class_valid);
    endtask

    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        {nrst, rd, wr, send, addr, wdata, fin} = '0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rdchk("max_len", rxfc_pkg::OFF_MAXLEN, 32'h0000_05ee);
        rdchk("buf_ofs", rxfc_pkg::OFF_BUF_OFS, 32'h0);
        rdchk("low_thr", rxfc_pkg::OFF_LOW_THR, 32'h0);
        rdchk("uni", rxfc_pkg::OFF_UNI_SET, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rdchk("flow_thr", rxfc_pkg::OFF_FLOW_THR0 + 8'(4 * i), 0);
        end
        rdchk("unmapped", rxfc_pkg::OFF_LIMIT, rxfc_pkg::UNMAPPED_RD);
        foreach (ROWS[i]) begin
            frm(3'h0, ROWS[i][21:6], ROWS[i][5:3], 1'b0);
            check("class", ROWS[i][2:0], {cls.long_frame, cls.oversized, cls.jabber});
            check("sop_ofs", 0, cls.sop_buf_offset);
        end
        bus(1'b1, rxfc_pkg::OFF_MAXLEN, 32'hffff_0040);
        rdchk("max_len", rxfc_pkg::OFF_MAXLEN, 32'h0000_0040);
        frm(3'h2, 16'h0041, 3'b000, 1'b0);
        check("long", 1, cls.long_frame);
        frm(3'h2, 16'h0040, 3'b000, 1'b0);
        check("long", 0, cls.long_frame);
        bus(1'b1, rxfc_pkg::OFF_BUF_OFS, 32'hffff_000f);
        rdchk("buf_ofs", rxfc_pkg::OFF_BUF_OFS, 32'h0000_000f);
        for (int i = 3; i < 8; i++) begin
            frm(3'(i), 16'h0010, 3'b000, 1'b0);
            check("sop_ofs", 16'h000f, cls.sop_buf_offset);
        end
        bus(1'b1, rxfc_pkg::OFF_UNI_SET, 32'h0000_00ff);
        bus(1'b1, rxfc_pkg::OFF_UNI_CLR, 32'h0000_00a5);
        bus(1'b1, rxfc_pkg::OFF_UNI_CLR, 32'h0);
        rdchk("uni", rxfc_pkg::OFF_UNI_CLR, 32'h0000_005a);
        check("uni_pins", 8'h5a, uni);
        bus(1'b1, rxfc_pkg::OFF_LOW_THR, 32'hffff_ff02);
        rdchk("low_thr", rxfc_pkg::OFF_LOW_THR, 32'h0000_0002);
        bus(1'b1, rxfc_pkg::OFF_FREE_CNT0 + 8'h04, 32'h2);
        frm(3'h1, 16'h0010, 3'b000, 1'b1);
        check("low_filt", 1, cls.low_filtered);
        frm(3'h1, 16'h0010, 3'b000, 1'b0);
        check("low_filt", 0, cls.low_filtered);
        bus(1'b1, rxfc_pkg::OFF_FREE_CNT0 + 8'h04, 32'h3);
        frm(3'h1, 16'h0010, 3'b000, 1'b1);
        check("low_filt", 0, cls.low_filtered);
        bus(1'b1, rxfc_pkg::OFF_LOW_THR, 32'h0);
        frm(3'h1, 16'h0010, 3'b000, 1'b1);
        check("low_filt", 0, cls.low_filtered);
        bus(1'b1, rxfc_pkg::OFF_FLOW_THR0 + 8'h04, 32'hffff_ff05);
        rdchk("flow_thr", rxfc_pkg::OFF_FLOW_THR0 + 8'h04, 32'h5);
        check("flow_off", 0, flow[1]);
        bus(1'b1, rxfc_pkg::OFF_FLOW_CTL, 32'h1);
        @(negedge clock);
        check("flow", 2'b10, flow[1:0]);
        frm(3'h1, 16'h0010, 3'b000, 1'b0);
        check("flow_ctl", 1, cls.flow_ctl);
        bus(1'b1, rxfc_pkg::OFF_FLOW_CTL, 32'h0);
        bus(1'b0, rxfc_pkg::OFF_IRQ_STAT, 32'h0);
        frm(3'h0, 16'h0041, 3'b000, 1'b0);
        check("irq_masked", 0, irq);
        bus(1'b1, rxfc_pkg::OFF_IRQ_MASK, 32'h1 << rxfc_pkg::IRQ_OVER);
        @(negedge clock);
        check("irq", 1, irq);
        rdchk("irq_stat", rxfc_pkg::OFF_IRQ_STAT, 32'h3);
        @(negedge clock);
        check("irq_clr", 0, irq);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rdchk("max_len", rxfc_pkg::OFF_MAXLEN, 32'h0000_05ee);
        check("uni_pins", 0, uni);
        give_verdict();
    end
endmodule
